// ==== dv/iosac_mem_model.sv ====
`timescale 1ns/1ns
module iosac_mem_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] gap,
  output logic            io_access,
  output logic            insn_done
);
  initial begin
    io_access = 1'b0;
    insn_done = 1'b0;
    forever begin
      @(posedge clk iff go);
      @(negedge clk);
      // One short I/O reference, no fault after it
      io_access = 1'b1;
      @(negedge clk);
      io_access = 1'b0;
      repeat (gap) @(negedge clk);
      insn_done = 1'b1;
      @(negedge clk);
      insn_done = 1'b0;
    end
  end
endmodule

// ==== dv/iosac_sva_asserts.sv ====
`timescale 1ns/1ns
`include "iosac_defs.svh"
module iosac_sva
  import iosac_pkg::*;
#(
  parameter int NOPND        = 6,
  parameter bit CTL_IN_IO_OK = 1'b0
)(
  input wire logic                    CLK_SYS,
  input wire logic                    SYS_RST,
  input wire logic                    CE,
  input wire logic                    DEC_VALID,
  input wire iosac_insn_s             DEC_INSN,
  input wire iosac_opnd_s [NOPND-1:0] DEC_OPND,
  input wire logic                    IO_ACCESS,
  input wire logic                    INSN_DONE,
  input wire logic                    PC_IN_IO,
  input wire logic                    SP_IN_IO,
  input wire logic                    PCB_IN_IO,
  input wire logic                    RES_VALID,
  input wire logic                    IO_LEGAL,
  input wire logic [NOPND-1:0]        OPND_IO_OK,
  input wire logic                    CRASH_LONG,
  input wire logic                    CRASH_WORD,
  input wire logic                    OPC_RESERVED,
  input wire logic                    CTL_IO_VIOL,
  input wire logic                    INT_HOLD
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  logic take;
  assign take = CE && DEC_VALID;
  ////////////////////////////////////////////////////////////
  res_answer_a: assert property (take |=> RES_VALID)
    else $error("no result after decode");
  legal_or_a: assert property (
    RES_VALID |-> IO_LEGAL == |OPND_IO_OK)
    else $error("legal flag disagrees with operands");
  kernel_excl_a: assert property (
    take && !DEC_INSN.kernel_set |=> !IO_LEGAL)
    else $error("non-kernel instruction allowed");
  slow_excl_a: assert property (
    take && DEC_INSN.slow |=> !IO_LEGAL)
    else $error("slow instruction allowed");
  branch_displ_a: assert property (
    take && DEC_INSN.opnd_cnt == 3'h2 &&
    DEC_OPND[1].access == IOSAC_ACC_BRANCH |=> !OPND_IO_OK[1])
    else $error("branch displacement allowed");
  restart_excl_a: assert property (
    take && DEC_INSN.restartable |=> !IO_LEGAL)
    else $error("restartable instruction allowed");
  wide_type_a: assert property (take && DEC_INSN.opnd_cnt != 3'h0 &&
    DEC_OPND[0].dtype > IOSAC_DT_LONG |=> !OPND_IO_OK[0])
    else $error("wide operand allowed");
  opc_reserved_a: assert property (take &&
    DEC_INSN.opcode == `IOSAC_OPC_RESERVED &&
    DEC_INSN.opc_len == `IOSAC_LEN_THREE |=> OPC_RESERVED && !IO_LEGAL)
    else $error("reserved opcode not flagged");
  crash_long_a: assert property (take &&
    DEC_INSN.opcode == `IOSAC_OPC_CRASH_LONG &&
    DEC_INSN.opc_len == `IOSAC_LEN_TWO |=> CRASH_LONG && !CRASH_WORD)
    else $error("crash report opcode missed");
  hold_cause_a: assert property (
    $rose(INT_HOLD) |-> $past(IO_ACCESS))
    else $error("hold without I/O access");
  hold_end_a: assert property (
    INT_HOLD && CE && INSN_DONE |=> !INT_HOLD)
    else $error("hold outlives instruction");
  ctl_pointer_a: assert property (CE && !CTL_IN_IO_OK &&
    (PC_IN_IO || SP_IN_IO || PCB_IN_IO) |=> CTL_IO_VIOL)
    else $error("pointer in I/O not flagged");
  cover property ($rose(INT_HOLD));
  cover property (CRASH_WORD);
  cover property (OPC_RESERVED);
endmodule
bind iosac_checker iosac_sva #(.NOPND(NOPND), .CTL_IN_IO_OK(CTL_IN_IO_OK))
  u_sva (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CE(CE),
  .DEC_VALID(DEC_VALID), .DEC_INSN(DEC_INSN), .DEC_OPND(DEC_OPND),
  .IO_ACCESS(IO_ACCESS), .INSN_DONE(INSN_DONE), .PC_IN_IO(PC_IN_IO),
  .SP_IN_IO(SP_IN_IO), .PCB_IN_IO(PCB_IN_IO), .RES_VALID(RES_VALID),
  .IO_LEGAL(IO_LEGAL), .OPND_IO_OK(OPND_IO_OK), .CRASH_LONG(CRASH_LONG),
  .CRASH_WORD(CRASH_WORD), .OPC_RESERVED(OPC_RESERVED),
  .CTL_IO_VIOL(CTL_IO_VIOL), .INT_HOLD(INT_HOLD));

// ==== dv/iosac_tb.sv ====
`timescale 1ns/1ns
`include "iosac_defs.svh"
module testbench;
  import iosac_pkg::*;
  logic              clk, rst, ce, dv, io_acc, done, go;
  logic              pc_io, sp_io, pcb_io, res_v, legal;
  logic              c_long, c_word, resv, viol, hold;
  logic [5:0]        ok;
  iosac_insn_s       insn;
  iosac_opnd_s [5:0] opnd;
  int                n_fail, n_compared;
  iosac_checker dut (.CLK_SYS(clk), .SYS_RST(rst), .CE(ce),
    .DEC_VALID(dv), .DEC_INSN(insn), .DEC_OPND(opnd), .IO_ACCESS(io_acc),
    .INSN_DONE(done), .PC_IN_IO(pc_io), .SP_IN_IO(sp_io),
    .PCB_IN_IO(pcb_io), .RES_VALID(res_v), .IO_LEGAL(legal),
    .OPND_IO_OK(ok), .CRASH_LONG(c_long), .CRASH_WORD(c_word),
    .OPC_RESERVED(resv), .CTL_IO_VIOL(viol), .INT_HOLD(hold));
  iosac_mem_model mem (.clk(clk), .go(go), .gap(4'h3),
    .io_access(io_acc), .insn_done(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic base();
    insn = '0;
    opnd = '0;
    insn.opcode = 24'h0000D0;
    insn.opc_len = 2'h1;
    insn.kernel_set = 1'b1;
    insn.opnd_cnt = 3'h2;
    opnd[0] = '{IOSAC_ACC_READ, IOSAC_DT_LONG, 4'h5, 1'b0, 1'b0};
    opnd[1] = '{IOSAC_ACC_WRITE, IOSAC_DT_LONG, 4'h5, 1'b0, 1'b0};
  endtask
  task automatic issue();
    @(negedge clk);
    dv = 1'b1;
    @(negedge clk);
    dv = 1'b0;
  endtask
  task automatic run_io(logic exp);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    @(negedge clk);
    chk("hold_on", hold, exp);
    repeat (3) @(negedge clk);
    chk("hold_kept", hold, exp);
    @(negedge clk);
    chk("hold_off", hold, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_legal();
    base();
    issue();
    chk("res_valid", res_v, 1'b1);
    chk("opnd_ok", ok, 8'h03);
    run_io(1'b1);
  endtask
  task automatic t_defer();
    for (int m = 9; m < 16; m += 2) begin
      base();
      opnd[0].mode = 4'(m);
      opnd[0].indexed = (m == 13);
      issue();
      chk("defer_legal", legal, 1'b1);
      run_io(1'b0);
    end
  endtask
  task automatic t_excl();
    for (int k = 0; k < 3; k++) begin
      base();
      insn.restartable = (k == 0);
      insn.kernel_set = (k != 1);
      insn.slow = (k == 2);
      issue();
      chk("excluded", legal, 1'b0);
    end
  endtask
  task automatic t_types();
    for (int d = 3; d < 12; d++) begin
      base();
      opnd[0].dtype = iosac_dtype_e'(4'(d));
      issue();
      chk("type_ok", ok, 8'h02);
    end
    base();
    opnd[0].desc_of_excl = 1'b1;
    issue();
    chk("desc_ok", ok, 8'h02);
  endtask
  task automatic t_dest();
    base();
    opnd[0].access = IOSAC_ACC_MODIFY;
    issue();
    chk("two_dest", legal, 1'b0);
    base();
    opnd[0].access = IOSAC_ACC_WRITE;
    opnd[1].access = IOSAC_ACC_READ;
    issue();
    chk("dest_not_last", legal, 1'b0);
  endtask
  task automatic t_special();
    base();
    insn.low_bit_branch = 1'b1;
    opnd[1] = '{IOSAC_ACC_BRANCH, IOSAC_DT_BYTE, 4'h0, 1'b0, 1'b0};
    issue();
    chk("blb_ok", ok, 8'h01);
    base();
    insn.queue_remove = 1'b1;
    issue();
    chk("queue_ok", ok, 8'h02);
    base();
    insn.queue_remove = 1'b1;
    opnd[1].dtype = IOSAC_DT_QUAD;
    issue();
    chk("queue_type", ok, 8'h00);
    base();
    insn.ext_func_call = 1'b1;
    issue();
    chk("ext_call_ok", ok, 8'h00);
  endtask
  task automatic t_opc();
    for (int k = 0; k < 3; k++) begin
      base();
      insn.opcode = (k == 0) ? `IOSAC_OPC_CRASH_LONG :
        (k == 1) ? `IOSAC_OPC_CRASH_WORD : `IOSAC_OPC_RESERVED;
      insn.opc_len = (k == 2) ? `IOSAC_LEN_THREE : `IOSAC_LEN_TWO;
      issue();
      chk("crash_long", c_long, k == 0);
      chk("crash_word", c_word, k == 1);
      chk("reserved", resv, k == 2);
    end
    chk("resv_legal", legal, 1'b0);
  endtask
  task automatic t_ctl();
    for (int k = 0; k < 3; k++) begin
      {pc_io, sp_io, pcb_io} = 3'b100 >> k;
      @(negedge clk);
      chk("ctl_viol", viol, 1'b1);
    end
    {pc_io, sp_io, pcb_io} = 3'b000;
    ce = 1'b0;
    @(negedge clk);
    chk("ctl_frozen", viol, 1'b1);
    ce = 1'b1;
    @(negedge clk);
    chk("ctl_clear", viol, 1'b0);
  endtask
  initial begin
    n_fail = 0;
    n_compared = 0;
    rst = 1'b1;
    ce = 1'b1;
    dv = 1'b0;
    go = 1'b0;
    {pc_io, sp_io, pcb_io} = 3'b000;
    base();
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_legal();
    t_defer();
    t_excl();
    t_types();
    t_dest();
    t_special();
    t_opc();
    t_ctl();
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule

// ==== rtl/iosac_checker.sv ====
`timescale 1ns/1ns
module iosac_checker
  import iosac_pkg::*;
#(
  parameter int          NOPND          = `IOSAC_MAX_OPND,
  parameter bit          EXT_CALL_IO_OK = 1'b0,
  parameter bit          CTL_IN_IO_OK   = 1'b0
)(
  input  wire logic                   CLK_SYS,
  input  wire logic                   SYS_RST,
  input  wire logic                   CE,
  input  wire logic                   DEC_VALID,
  input  wire iosac_insn_s            DEC_INSN,
  input  wire iosac_opnd_s [NOPND-1:0] DEC_OPND,
  input  wire logic                   IO_ACCESS,
  input  wire logic                   INSN_DONE,
  input  wire logic                   PC_IN_IO,
  input  wire logic                   SP_IN_IO,
  input  wire logic                   PCB_IN_IO,
  output logic                        RES_VALID,
  output logic                        IO_LEGAL,
  output logic [NOPND-1:0]            OPND_IO_OK,
  output logic                        CRASH_LONG,
  output logic                        CRASH_WORD,
  output logic                        OPC_RESERVED,
  output logic                        CTL_IO_VIOL,
  output logic                        INT_HOLD
);
  // Operand count must fit the opnd_cnt field and the carrier
  if (NOPND < 1 || NOPND > `IOSAC_MAX_OPND) begin : g_bad_nopnd
    $error("NOPND out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-operand classification
  logic [NOPND-1:0] type_ok;
  logic [NOPND-1:0] is_dest;
  logic [NOPND-1:0] is_def;
  logic [NOPND-1:0] is_br;
  logic [NOPND-1:0] present;

  genvar gi;
  generate
    for (gi = 0; gi < NOPND; gi = gi + 1) begin : g_opnd
      assign present[gi] = (int'(DEC_INSN.opnd_cnt) > gi);
      iosac_opnd_class u_class (
        .opnd        (DEC_OPND[gi]),
        .present     (present[gi]),
        .type_ok     (type_ok[gi]),
        .is_dest     (is_dest[gi]),
        .is_deferred (is_def[gi]),
        .is_branch   (is_br[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Instruction classification
  logic             crash_long_c;
  logic             crash_word_c;
  logic             reserved_c;
  logic             dest_ok_c;
  logic             base_elig_c;
  logic             any_def_c;
  logic             legal_c;
  logic [NOPND-1:0] opnd_ok_c;
  logic             ctl_viol_c;
  int               ndest;
  int               last;

  always_comb begin
    ndest = 0;
    last  = 0;
    for (int i = 0; i < NOPND; i++) begin
      if (is_dest[i]) begin
        ndest = ndest + 1;
      end
      if (present[i]) begin
        last = i;
      end
    end
    // Single destination, and only in the final operand position
    dest_ok_c = (ndest == 0) ||
                (ndest == 1 && is_dest[last]);
    crash_long_c = (DEC_INSN.opc_len == `IOSAC_LEN_TWO) &&
                   (DEC_INSN.opcode == `IOSAC_OPC_CRASH_LONG);
    crash_word_c = (DEC_INSN.opc_len == `IOSAC_LEN_TWO) &&
                   (DEC_INSN.opcode == `IOSAC_OPC_CRASH_WORD);
    reserved_c   = (DEC_INSN.opc_len == `IOSAC_LEN_THREE) &&
                   (DEC_INSN.opcode == `IOSAC_OPC_RESERVED);
    base_elig_c  = !DEC_INSN.restartable &&
                   DEC_INSN.kernel_set &&
                   !DEC_INSN.slow &&
                   !reserved_c;
    any_def_c    = |is_def;
    opnd_ok_c    = '0;
    if (!base_elig_c) begin
      opnd_ok_c = '0;
    end else if (DEC_INSN.low_bit_branch) begin
      opnd_ok_c = type_ok & ~is_br;
    end else if (DEC_INSN.queue_remove) begin
      for (int i = 0; i < NOPND; i++) begin
        opnd_ok_c[i] = type_ok[i] && (i == last) &&
                       DEC_OPND[i].access == IOSAC_ACC_WRITE;
      end
    end else if (DEC_INSN.ext_func_call) begin
      opnd_ok_c = EXT_CALL_IO_OK ? (type_ok & ~is_br) : '0;
    end else if (dest_ok_c) begin
      opnd_ok_c = type_ok & ~is_br;
    end
    legal_c    = |opnd_ok_c;
    // Control pointers in I/O only where the implementation allows it
    ctl_viol_c = !CTL_IN_IO_OK &&
                 (PC_IN_IO || SP_IN_IO || PCB_IN_IO);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered decode result
  logic             res_valid_reg,  res_valid_next;
  logic             io_legal_reg,   io_legal_next;
  logic [NOPND-1:0] opnd_ok_reg,    opnd_ok_next;
  logic             crash_long_reg, crash_long_next;
  logic             crash_word_reg, crash_word_next;
  logic             reserved_reg,   reserved_next;
  logic             ctl_viol_reg,   ctl_viol_next;

  always_comb begin
    res_valid_next  = DEC_VALID;
    io_legal_next   = io_legal_reg;
    opnd_ok_next    = opnd_ok_reg;
    crash_long_next = crash_long_reg;
    crash_word_next = crash_word_reg;
    reserved_next   = reserved_reg;
    ctl_viol_next   = ctl_viol_c;
    if (DEC_VALID) begin
      io_legal_next   = legal_c;
      opnd_ok_next    = opnd_ok_c;
      crash_long_next = crash_long_c;
      crash_word_next = crash_word_c;
      reserved_next   = reserved_c;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      res_valid_reg  <= `IOSAC_RST_FLAG;
      io_legal_reg   <= `IOSAC_RST_FLAG;
      opnd_ok_reg    <= '0;
      crash_long_reg <= `IOSAC_RST_FLAG;
      crash_word_reg <= `IOSAC_RST_FLAG;
      reserved_reg   <= `IOSAC_RST_FLAG;
      ctl_viol_reg   <= `IOSAC_RST_FLAG;
    end else if (CE) begin
      res_valid_reg  <= res_valid_next;
      io_legal_reg   <= io_legal_next;
      opnd_ok_reg    <= opnd_ok_next;
      crash_long_reg <= crash_long_next;
      crash_word_reg <= crash_word_next;
      reserved_reg   <= reserved_next;
      ctl_viol_reg   <= ctl_viol_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt hold sequencer
  iosac_state_e state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IOSAC_ST_IDLE: begin
        // Deferred modes keep the instruction interruptible
        if (DEC_VALID && legal_c && !any_def_c) begin
          state_next = IOSAC_ST_ARMED;
        end
      end
      IOSAC_ST_ARMED: begin
        if (INSN_DONE) begin
          state_next = IOSAC_ST_IDLE;
        end else if (IO_ACCESS) begin
          state_next = IOSAC_ST_HOLD;
        end
      end
      IOSAC_ST_HOLD: begin
        if (INSN_DONE) begin
          state_next = IOSAC_ST_IDLE;
        end
      end
      default: state_next = IOSAC_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= IOSAC_ST_IDLE;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  assign RES_VALID    = res_valid_reg;
  assign IO_LEGAL     = io_legal_reg;
  assign OPND_IO_OK   = opnd_ok_reg;
  assign CRASH_LONG   = crash_long_reg;
  assign CRASH_WORD   = crash_word_reg;
  assign OPC_RESERVED = reserved_reg;
  assign CTL_IO_VIOL  = ctl_viol_reg;
  assign INT_HOLD     = (state_reg == IOSAC_ST_HOLD);
endmodule

// ==== rtl/iosac_defs.svh ====
`ifndef IOSAC_DEFS_SVH
`define IOSAC_DEFS_SVH

// Widths of the decoded instruction carrier
`define IOSAC_OPC_W        24
`define IOSAC_OPC_LEN_W    2
`define IOSAC_MODE_W       4
`define IOSAC_MAX_OPND     6
`define IOSAC_CNT_W        3

// Extended opcode codes, low byte first as printed
`define IOSAC_OPC_CRASH_LONG  24'h00FDFF
`define IOSAC_OPC_CRASH_WORD  24'h00FEFF
`define IOSAC_OPC_RESERVED    24'hFFFFFF
`define IOSAC_LEN_TWO         2'h2
`define IOSAC_LEN_THREE       2'h3

// Deferred specifier modes that may let interrupts in
`define IOSAC_MODE_AUTOINC_DEF  4'h9
`define IOSAC_MODE_BDISP_DEF    4'hB
`define IOSAC_MODE_WDISP_DEF    4'hD
`define IOSAC_MODE_LDISP_DEF    4'hF

// Reset values
`define IOSAC_RST_FLAG  1'h0

`endif

// ==== rtl/iosac_opnd_class.sv ====
`timescale 1ns/1ns
module iosac_opnd_class
  import iosac_pkg::*;
(
  input  wire iosac_opnd_s opnd,
  input  wire logic        present,
  output logic             type_ok,
  output logic             is_dest,
  output logic             is_deferred,
  output logic             is_branch
);
  always_comb begin
    // Quad, octa, floating, field and queue data stay out of I/O space
    case (opnd.dtype)
      IOSAC_DT_BYTE,
      IOSAC_DT_WORD,
      IOSAC_DT_LONG: type_ok = present && !opnd.desc_of_excl;
      default:       type_ok = 1'b0;
    endcase
    // Modified operands count as destinations too
    is_dest = present && (opnd.access == IOSAC_ACC_WRITE ||
                          opnd.access == IOSAC_ACC_MODIFY);
    case (opnd.mode)
      `IOSAC_MODE_AUTOINC_DEF,
      `IOSAC_MODE_BDISP_DEF,
      `IOSAC_MODE_WDISP_DEF,
      `IOSAC_MODE_LDISP_DEF: is_deferred = present;
      default:               is_deferred = 1'b0;
    endcase
    is_branch = present && (opnd.access == IOSAC_ACC_BRANCH);
  end
endmodule

// ==== rtl/iosac_pkg.sv ====
package iosac_pkg;
  `include "iosac_defs.svh"

  typedef enum logic [2:0] {
    IOSAC_ACC_ADDR   = 3'h0,
    IOSAC_ACC_BRANCH = 3'h1,
    IOSAC_ACC_MODIFY = 3'h2,
    IOSAC_ACC_READ   = 3'h3,
    IOSAC_ACC_FIELD  = 3'h4,
    IOSAC_ACC_WRITE  = 3'h5
  } iosac_access_e;

  typedef enum logic [3:0] {
    IOSAC_DT_BYTE  = 4'h0,
    IOSAC_DT_WORD  = 4'h1,
    IOSAC_DT_LONG  = 4'h2,
    IOSAC_DT_QUAD  = 4'h3,
    IOSAC_DT_OCTA  = 4'h4,
    IOSAC_DT_FFLT  = 4'h5,
    IOSAC_DT_DFLT  = 4'h6,
    IOSAC_DT_GFLT  = 4'h7,
    IOSAC_DT_HFLT  = 4'h8,
    IOSAC_DT_FIELD = 4'h9,
    IOSAC_DT_QUEUE = 4'hA,
    IOSAC_DT_MULTI = 4'hB
  } iosac_dtype_e;

  typedef enum logic [1:0] {
    IOSAC_ST_IDLE  = 2'b00,
    IOSAC_ST_ARMED = 2'b01,
    IOSAC_ST_HOLD  = 2'b11
  } iosac_state_e;

  typedef struct packed {
    iosac_access_e                access;
    iosac_dtype_e                 dtype;
    logic [`IOSAC_MODE_W-1:0]     mode;
    logic                         indexed;
    logic                         desc_of_excl;
  } iosac_opnd_s;

  typedef struct packed {
    logic [`IOSAC_OPC_W-1:0]      opcode;
    logic [`IOSAC_OPC_LEN_W-1:0]  opc_len;
    logic                         restartable;
    logic                         kernel_set;
    logic                         slow;
    logic                         low_bit_branch;
    logic                         queue_remove;
    logic                         ext_func_call;
    logic [`IOSAC_CNT_W-1:0]      opnd_cnt;
  } iosac_insn_s;
endpackage
